// File: core/ash_defines.vh
// timing constants and cycle counts for the async sram host controller
`ifndef ASH_DEFINES_VH
`define ASH_DEFINES_VH

// controller clock
`define ASH_CLK_PERIOD_NS 8

// round a least time in ns up to whole clock cycles, never below one
`define ASH_CYC_UP(t) ((((t) + `ASH_CLK_PERIOD_NS - 1) / `ASH_CLK_PERIOD_NS) < 1 ? 1 : \
  (((t) + `ASH_CLK_PERIOD_NS - 1) / `ASH_CLK_PERIOD_NS))
`define ASH_MAX(a, b) (((a) > (b)) ? (a) : (b))

// memory timing, fastest speed grade, in ns
`define ASH_READ_PERIOD_MIN_NS 250
`define ASH_ADDR_TO_DATA_DELAY_NS 250
`define ASH_SELECT_TO_DATA_DELAY_NS 125
`define ASH_FLOAT_LOW_TO_DATA_DELAY_NS 100
`define ASH_READ_DATA_HOLD_NS 30
`define ASH_FLOAT_CTL_TO_HIZ_DELAY_NS 75
`define ASH_DESELECT_TO_HIZ_DELAY_NS 100
`define ASH_WRITE_PERIOD_MIN_NS 250
`define ASH_ADDR_BEFORE_STROBE_NS 0
`define ASH_STROBE_LOW_MIN_NS 100
`define ASH_SELECT_BEFORE_STROBE_RISE_NS 100
`define ASH_ADDR_AFTER_STROBE_NS 0
`define ASH_WDATA_BEFORE_STROBE_RISE_NS 85
`define ASH_WDATA_AFTER_STROBE_RISE_NS 0

// stages of the data pin synchroniser
`define ASH_SYNC_STAGES 2

// derived cycle counts
`define ASH_READ_PERIOD_CYC `ASH_CYC_UP(`ASH_READ_PERIOD_MIN_NS)
`define ASH_ACCESS_CYC `ASH_MAX(`ASH_CYC_UP(`ASH_ADDR_TO_DATA_DELAY_NS), \
  `ASH_MAX(`ASH_CYC_UP(`ASH_SELECT_TO_DATA_DELAY_NS), \
  `ASH_CYC_UP(`ASH_FLOAT_LOW_TO_DATA_DELAY_NS)))
// whole read: access, synchroniser, one cycle margin, at least the read period
`define ASH_READ_CYC `ASH_MAX(`ASH_READ_PERIOD_CYC, `ASH_ACCESS_CYC + `ASH_SYNC_STAGES + 1)
`define ASH_TURN_CYC `ASH_MAX(`ASH_CYC_UP(`ASH_DESELECT_TO_HIZ_DELAY_NS), \
  `ASH_CYC_UP(`ASH_FLOAT_CTL_TO_HIZ_DELAY_NS))
`define ASH_WRITE_PERIOD_CYC `ASH_CYC_UP(`ASH_WRITE_PERIOD_MIN_NS)
`define ASH_STROBE_CYC `ASH_MAX(`ASH_CYC_UP(`ASH_STROBE_LOW_MIN_NS), \
  `ASH_MAX(`ASH_CYC_UP(`ASH_SELECT_BEFORE_STROBE_RISE_NS), \
  `ASH_CYC_UP(`ASH_WDATA_BEFORE_STROBE_RISE_NS)))
`define ASH_RECOVERY_CYC `ASH_READ_PERIOD_CYC

// reset values of the pins
`define ASH_ADDR_RESET 8'h00
`define ASH_DATA_RESET 4'h0

`endif

// File: core/ash_sync.v
// two-stage synchroniser for a bus of level inputs
`timescale 1ns/1ps
module ash_sync #(
  parameter WIDTH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  // one pair of flops per bit; the first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate

endmodule

// File: core/ash_timer.v
// loadable down counter that times each phase of an access
`timescale 1ns/1ps
module ash_timer #(
  parameter CNT_W = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire load,
  input wire [CNT_W-1:0] load_val,
  output wire done
);

  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;

  // load wins; otherwise count down and rest at zero
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != {CNT_W{1'b0}}) begin
      count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= {CNT_W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

  // done in the last cycle of a phase loaded with its length minus one
  assign done = (count_reg == {CNT_W{1'b0}});

endmodule

// File: core/ash_host.v
// host controller for a 256x4 asynchronous static memory with common i/o
`timescale 1ns/1ps
`include "ash_defines.vh"
module ash_host #(
  parameter ADDR_W = 8,
  parameter DATA_W = 4,
  parameter CNT_W = 8,
  parameter READ_CYC = `ASH_READ_CYC,
  parameter TURN_CYC = `ASH_TURN_CYC,
  parameter WRITE_CYC = `ASH_WRITE_PERIOD_CYC,
  parameter STROBE_CYC = `ASH_STROBE_CYC,
  parameter RECOVERY_CYC = `ASH_RECOVERY_CYC
) (
  input wire ref_clk,
  input wire rst,
  // user request side
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  output wire rsp_valid,
  output wire [DATA_W-1:0] rsp_rdata,
  output wire wr_done,
  // standby control
  input wire standby_req,
  output wire standby_active,
  // memory pins
  output wire [ADDR_W-1:0] mem_addr,
  output wire select_one_n,
  output wire select_two_n,
  output wire write_strobe_n,
  output wire output_float_ctl,
  input wire [DATA_W-1:0] mem_data_in,
  output wire [DATA_W-1:0] mem_data_out,
  output wire mem_data_oe
);

  // controller states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_READ = 3'h1;
  localparam [2:0] ST_TURN = 3'h2;
  localparam [2:0] ST_WSET = 3'h3;
  localparam [2:0] ST_WSTB = 3'h4;
  localparam [2:0] ST_WHLD = 3'h5;
  localparam [2:0] ST_STBY = 3'h6;
  localparam [2:0] ST_RECOV = 3'h7;

  // phase loads: a phase of n cycles loads n-1; counts above the timer width wrap
  localparam [31:0] LD_READ_FULL = READ_CYC - 1;
  localparam [31:0] LD_TURN_FULL = TURN_CYC - 1;
  localparam [31:0] LD_WSTB_FULL = STROBE_CYC - 1;
  localparam [CNT_W-1:0] LD_READ = LD_READ_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] LD_TURN = LD_TURN_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] LD_WSET = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] LD_WSTB = LD_WSTB_FULL[CNT_W-1:0];
  // setup cycle + strobe + hold fill the write period; hold is at least one
  localparam HOLD_CYC = (WRITE_CYC - STROBE_CYC - 1 < 1) ? 1
                        : (WRITE_CYC - STROBE_CYC - 1);
  localparam [31:0] LD_WHLD_FULL = HOLD_CYC - 1;
  localparam [31:0] LD_RECOV_FULL = RECOVERY_CYC - 1;
  localparam [CNT_W-1:0] LD_WHLD = LD_WHLD_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] LD_RECOV = LD_RECOV_FULL[CNT_W-1:0];

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [ADDR_W-1:0] addr_reg;
  reg [ADDR_W-1:0] addr_next;
  reg [DATA_W-1:0] wdata_reg;
  reg [DATA_W-1:0] wdata_next;
  reg sel_n_reg;
  reg sel_n_next;
  reg strobe_n_reg;
  reg strobe_n_next;
  reg float_reg;
  reg float_next;
  reg oe_reg;
  reg oe_next;
  reg stby_reg;
  reg stby_next;
  reg rsp_valid_reg;
  reg rsp_valid_next;
  reg [DATA_W-1:0] rdata_reg;
  reg [DATA_W-1:0] rdata_next;
  reg wr_done_reg;
  reg wr_done_next;
  reg tmr_load;
  reg [CNT_W-1:0] tmr_val;

  wire tmr_done;
  wire [DATA_W-1:0] data_sync;
  wire take_req;

  // data pins come from the memory's own timing, so synchronise them
  ash_sync #(
    .WIDTH(DATA_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(mem_data_in),
    .sync_out(data_sync)
  );

  // one timer serves every phase; phases never overlap
  ash_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // requests only in idle and never while standby is asked for
  assign req_ready = (state_reg == ST_IDLE) && !standby_req;
  assign take_req = req_valid && req_ready;

  // next state and phase timing
  always @* begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = {CNT_W{1'b0}};
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    case (state_reg)
      ST_IDLE: begin
        if (standby_req) begin
          state_next = ST_STBY;
        end else if (take_req) begin
          // address and data latched once, held for the whole access
          addr_next = req_addr;
          wdata_next = req_wdata;
          tmr_load = 1'b1;
          if (req_write) begin
            state_next = ST_WSET;
            tmr_val = LD_WSET;
          end else begin
            state_next = ST_READ;
            tmr_val = LD_READ;
          end
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          // let the memory release the pins before anyone drives them
          state_next = ST_TURN;
          tmr_load = 1'b1;
          tmr_val = LD_TURN;
        end
      end
      ST_TURN: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_WSET: begin
        // one cycle of address before the strobe falls
        if (tmr_done) begin
          state_next = ST_WSTB;
          tmr_load = 1'b1;
          tmr_val = LD_WSTB;
        end
      end
      ST_WSTB: begin
        if (tmr_done) begin
          state_next = ST_WHLD;
          tmr_load = 1'b1;
          tmr_val = LD_WHLD;
        end
      end
      ST_WHLD: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_STBY: begin
        // supply is low while here; leave only when standby is dropped
        if (!standby_req) begin
          state_next = ST_RECOV;
          tmr_load = 1'b1;
          tmr_val = LD_RECOV;
        end
      end
      ST_RECOV: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // pin levels follow the state being entered, so they change with it
  always @* begin
    sel_n_next = 1'b1;
    strobe_n_next = 1'b1;
    float_next = 1'b1;
    oe_next = 1'b0;
    stby_next = 1'b0;
    case (state_next)
      ST_READ: begin
        // selected, read level, outputs allowed
        sel_n_next = 1'b0;
        strobe_n_next = 1'b1;
        float_next = 1'b0;
      end
      ST_WSET: begin
        sel_n_next = 1'b0;
        float_next = 1'b1;
        oe_next = 1'b1;
      end
      ST_WSTB: begin
        sel_n_next = 1'b0;
        strobe_n_next = 1'b0;
        float_next = 1'b1;
        oe_next = 1'b1;
      end
      ST_WHLD: begin
        // strobe back high, address and data still held
        sel_n_next = 1'b0;
        float_next = 1'b1;
        oe_next = 1'b1;
      end
      ST_STBY: begin
        // deselected and floated throughout standby
        sel_n_next = 1'b1;
        stby_next = 1'b1;
      end
      default: begin
        sel_n_next = 1'b1;
      end
    endcase
  end

  // capture read data on the last cycle of the read phase
  always @* begin
    rsp_valid_next = 1'b0;
    rdata_next = rdata_reg;
    wr_done_next = 1'b0;
    if ((state_reg == ST_READ) && tmr_done) begin
      rsp_valid_next = 1'b1;
      rdata_next = data_sync;
    end
    if ((state_reg == ST_WHLD) && tmr_done) begin
      wr_done_next = 1'b1;
    end
  end

  // state and pin registers; reset leaves the memory deselected
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      addr_reg <= `ASH_ADDR_RESET;
      wdata_reg <= `ASH_DATA_RESET;
      sel_n_reg <= 1'b1;
      strobe_n_reg <= 1'b1;
      float_reg <= 1'b1;
      oe_reg <= 1'b0;
      stby_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg <= `ASH_DATA_RESET;
      wr_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      sel_n_reg <= sel_n_next;
      strobe_n_reg <= strobe_n_next;
      float_reg <= float_next;
      oe_reg <= oe_next;
      stby_reg <= stby_next;
      rsp_valid_reg <= rsp_valid_next;
      rdata_reg <= rdata_next;
      wr_done_reg <= wr_done_next;
    end
  end

  // both selects move together; the memory has no refresh to serve
  assign select_one_n = sel_n_reg;
  assign select_two_n = sel_n_reg;
  assign write_strobe_n = strobe_n_reg;
  assign output_float_ctl = float_reg;
  assign mem_addr = addr_reg;
  assign mem_data_out = wdata_reg;
  assign mem_data_oe = oe_reg;
  assign standby_active = stby_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;
  assign wr_done = wr_done_reg;

endmodule

// File: sim/ash_host_asserts.sv
// checker on the pins of the static memory host controller
`timescale 1ns/1ps
module ash_host_asserts #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 4,
  parameter int READ_CYC = 5,
  parameter int WRITE_CYC = 6,
  parameter int STROBE_CYC = 2
) (
  input wire ref_clk,
  input wire rst,
  input wire req_valid,
  input wire req_ready,
  input wire req_write,
  input wire rsp_valid,
  input wire wr_done,
  input wire standby_active,
  input wire [ADDR_W-1:0] mem_addr,
  input wire select_one_n,
  input wire select_two_n,
  input wire write_strobe_n,
  input wire output_float_ctl,
  input wire [DATA_W-1:0] mem_data_out,
  input wire mem_data_oe
);
  localparam int RD_LAT = READ_CYC + 1;
  localparam int WR_LAT = WRITE_CYC + 1;
  wire take = req_valid && req_ready;
  logic [11:0] low_cnt_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // length of the current strobe pulse, counted in whole cycles
  always @(posedge ref_clk or posedge rst) begin
    if (rst) low_cnt_reg <= 12'h000;
    else if (!write_strobe_n) low_cnt_reg <= low_cnt_reg + 12'h001;
    else low_cnt_reg <= 12'h000;
  end
  a_sel_pair: assert property (select_one_n == select_two_n)
    else $error("selects differ");
  a_read_pins: assert property (take && !req_write |=>
    (!select_one_n && !output_float_ctl && write_strobe_n && !mem_data_oe)[*5])
    else $error("read pins wrong");
  a_read_latency: assert property (take && !req_write |-> ##RD_LAT rsp_valid)
    else $error("read answer late");
  a_turn_float: assert property (rsp_valid |->
    (select_one_n && output_float_ctl && !req_ready)[*2])
    else $error("turnaround too short");
  a_write_latency: assert property (take && req_write |-> ##WR_LAT wr_done)
    else $error("write end late");
  a_write_float: assert property (!write_strobe_n |->
    output_float_ctl && mem_data_oe && !select_one_n)
    else $error("write without float");
  a_write_stable: assert property ((!write_strobe_n || $rose(write_strobe_n)) |->
    $stable(mem_addr) && $stable(mem_data_out))
    else $error("address or data moved");
  a_strobe_width: assert property ($rose(write_strobe_n) |-> low_cnt_reg == STROBE_CYC)
    else $error("strobe width wrong");
  a_standby_idle: assert property (standby_active |->
    select_one_n && output_float_ctl && !mem_data_oe && !req_ready)
    else $error("standby pins wrong");
  a_recovery_wait: assert property ($fell(standby_active) |-> (!req_ready)[*3])
    else $error("recovery too short");
  c_read: cover property (rsp_valid);
  c_write: cover property (wr_done);
  c_standby: cover property ($fell(standby_active));
endmodule
bind ash_host ash_host_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .READ_CYC(READ_CYC),
  .WRITE_CYC(WRITE_CYC), .STROBE_CYC(STROBE_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .rsp_valid(rsp_valid),
  .wr_done(wr_done), .standby_active(standby_active), .mem_addr(mem_addr),
  .select_one_n(select_one_n), .select_two_n(select_two_n), .write_strobe_n(write_strobe_n),
  .output_float_ctl(output_float_ctl), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

// File: sim/ash_mem_model.sv
// behavioural model of the 256x4 common-i/o static memory
`timescale 1ns/1ps
module ash_mem_model (
  input wire ref_clk,
  input wire [7:0] addr,
  input wire sel1_n,
  input wire sel2_n,
  input wire we_n,
  input wire float_ctl,
  input wire low_supply,
  input wire [3:0] dq,
  output logic [3:0] dq_drv,
  output wire dq_oe
);
  logic [3:0] cells [0:255];
  logic on_reg = 1'b0;
  // lowered supply cuts the cells off the pins
  wire sel = !sel1_n && !sel2_n && !low_supply;
  // drive only when selected, reading and not floated
  assign dq_oe = sel && we_n && !float_ctl;
  initial dq_drv = 4'h0;
  // store on strobe rise; static cells, no refresh
  always @(posedge we_n) begin
    if (sel) cells[addr] <= dq;
  end
  // data settles two cycles after the pins turn on, standing in for the access time;
  // unsettled or released pins toggle so an early or late sample never wins
  always @(posedge ref_clk) begin
    on_reg <= dq_oe;
    dq_drv <= (dq_oe && on_reg) ? cells[addr] : ~dq_drv;
  end
endmodule

// File: sim/tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb;
  localparam int RD = 5;
  localparam int WR = 6;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic standby_req = 1'b0;
  logic low_supply = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [3:0] req_wdata = 4'h0;
  wire req_ready, rsp_valid, wr_done, standby_active, select_one_n, select_two_n;
  wire write_strobe_n, output_float_ctl, mem_data_oe, dev_oe;
  wire [7:0] mem_addr;
  wire [3:0] rsp_rdata, mem_data_out, dev_drv;
  // host wins the wire when both drive; contention is flagged separately
  wire [3:0] dq = mem_data_oe ? mem_data_out : dev_drv;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h61220193;
  logic [3:0] ref_mem [0:255];
  logic [7:0] addr_q [$];

  ash_host #(.READ_CYC(RD), .TURN_CYC(2), .WRITE_CYC(WR), .STROBE_CYC(2), .RECOVERY_CYC(3)) uut (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .wr_done(wr_done), .standby_req(standby_req),
    .standby_active(standby_active), .mem_addr(mem_addr), .select_one_n(select_one_n),
    .select_two_n(select_two_n), .write_strobe_n(write_strobe_n),
    .output_float_ctl(output_float_ctl), .mem_data_in(dq), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe));
  ash_mem_model u_mem (.ref_clk(ref_clk), .addr(mem_addr), .sel1_n(select_one_n),
    .sel2_n(select_two_n), .we_n(write_strobe_n), .float_ctl(output_float_ctl),
    .low_supply(low_supply), .dq(dq), .dq_drv(dev_drv), .dq_oe(dev_oe));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one whole access; latency counted from the take edge
  task access(input logic w, input logic [7:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 200) check(n, 0, "ready_wait");
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((w ? wr_done : rsp_valid) !== 1'b1 && n < 100);
    if (w) begin
      check(n, WR + 1, "write_latency");
      ref_mem[a] = d;
    end else begin
      check(n, RD + 1, "read_latency");
      check(rsp_rdata, ref_mem[a], "read_data");
    end
  endtask

  // hang guard and bus contention watch
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end
  always @(negedge ref_clk) begin
    if (mem_data_oe === 1'b1 && dev_oe === 1'b1) check(1, 0, "bus_contention");
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    // boundary words first, then random ones
    addr_q = '{8'h00, 8'hFF};
    repeat (8) begin
      seed = lfsr(seed);
      addr_q.push_back(seed[7:0]);
    end
    foreach (addr_q[i]) begin
      seed = lfsr(seed);
      access(1'b1, addr_q[i], seed[11:8]);
    end
    foreach (addr_q[i]) access(1'b0, addr_q[i], 4'h0);
    // overwrite then read straight back
    access(1'b1, 8'hFF, ~ref_mem[8'hFF]);
    access(1'b0, 8'hFF, 4'h0);
    @(posedge ref_clk);
    standby_req <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check(standby_active, 1'b1, "standby_active");
    check({select_one_n, select_two_n, output_float_ctl, mem_data_oe}, 4'hE, "standby_pins");
    check(req_ready, 1'b0, "standby_refuse");
    @(posedge ref_clk);
    low_supply <= 1'b1;
    repeat (20) @(posedge ref_clk);
    low_supply <= 1'b0;
    standby_req <= 1'b0;
    // contents must survive the lowered supply
    foreach (addr_q[i]) access(1'b0, addr_q[i], 4'h0);
    test_done;
  end
endmodule
